/* File: src/pcsia_params.svh */
// Constants for the program counter, stack and indirect addressing block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PCSIA_PARAMS_SVH
`define PCSIA_PARAMS_SVH

// -----------------------------------------------------------------------------
// Widths and sizes
// -----------------------------------------------------------------------------
`define PCSIA_PC_W 13
`define PCSIA_TGT_W 11
`define PCSIA_LATCH_W 5
`define PCSIA_STACK_DEPTH 8
`define PCSIA_DADDR_W 9
`define PCSIA_PAGE_HI 4
`define PCSIA_PAGE_LO 3

// -----------------------------------------------------------------------------
// Register offsets (byte addresses on the bus)
// -----------------------------------------------------------------------------
`define PCSIA_OFS_PC_LOW 8'h00
`define PCSIA_OFS_LATCH 8'h04
`define PCSIA_OFS_POINTER 8'h08
`define PCSIA_OFS_BANK 8'h0c
`define PCSIA_OFS_PC_FULL 8'h10

// -----------------------------------------------------------------------------
// Reset values, fixed addresses and bus answers
// -----------------------------------------------------------------------------
`define PCSIA_PC_RST 13'h0000
`define PCSIA_LATCH_RST 5'h00
`define PCSIA_POINTER_RST 8'h00
`define PCSIA_BANK_RST 1'b0
`define PCSIA_IRQ_VECTOR 13'h0004
`define PCSIA_INDIRECT_LOC 7'h00
`define PCSIA_ZERO_BYTE 8'h00
`define PCSIA_PC_ONE 13'h0001
`define PCSIA_RESP_OKAY 2'h0
`define PCSIA_RESP_SLVERR 2'h2

`endif

/* File: src/pcsia_pkg.sv */
// Types shared by the program counter block and its helpers.
// Assumes the constants header sits on the include path.
`include "pcsia_params.svh"

package pcsia_pkg;

   // --------------------------------------------------------------------------
   // Carriers
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic step;
      logic call;
      logic jump;
      logic ret;
      logic irq;
      logic pcl_we;
      logic [`PCSIA_TGT_W-1:0] target;
      logic [7:0] pcl_data;
   } pcsia_ctl_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [`PCSIA_DADDR_W-1:0] addr;
      logic [7:0] wdata;
   } pcsia_dreq_t;

   typedef struct packed {
      logic re;
      logic we;
      logic zero_read;
      logic [`PCSIA_DADDR_W-1:0] addr;
      logic [7:0] wdata;
   } pcsia_dacc_t;

   typedef enum logic [2:0] {
      PCSIA_SEL_PC_LOW,
      PCSIA_SEL_LATCH,
      PCSIA_SEL_POINTER,
      PCSIA_SEL_BANK,
      PCSIA_SEL_PC_FULL,
      PCSIA_SEL_NONE
   } pcsia_sel_t;

endpackage

/* File: src/pcsia_stack.sv */
// Circular return-address stack held in flip-flops.
// Assumes push and pop never arrive together.
`timescale 1ns/1ns
`include "pcsia_params.svh"

module pcsia_stack #(
   parameter int DEPTH = `PCSIA_STACK_DEPTH,
   parameter int WIDTH = `PCSIA_PC_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0] ptr_q;
   logic [PW-1:0] ptr_d;

   // Pointer wraps with no overflow flag; old entries are overwritten
   always_comb begin
      mem_d = mem_q;
      ptr_d = ptr_q;
      if (push) begin
         mem_d[ptr_q] = push_data;
         ptr_d = ptr_q + PW'(1);
      end else if (pop) begin
         ptr_d = ptr_q - PW'(1);
      end
   end

   assign top = mem_q[ptr_q - PW'(1)];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr_q <= '0;
      end else begin
         ptr_q <= ptr_d;
      end
      mem_q <= mem_d;
   end
endmodule

/* File: src/pcsia_indirect.sv */
// Resolves a data access that names the indirect location.
// Assumes a direct address whose low seven bits match that location.
`timescale 1ns/1ns
`include "pcsia_params.svh"

module pcsia_indirect
   import pcsia_pkg::*;
(
   input pcsia_dreq_t req,
   input wire logic [7:0] pointer,
   input wire logic bank,
   output pcsia_dacc_t acc
);
   logic via_ptr;
   logic self_ref;

   always_comb begin
      via_ptr = req.addr[6:0] == `PCSIA_INDIRECT_LOC;
      self_ref = via_ptr && pointer[6:0] == `PCSIA_INDIRECT_LOC;
      acc.addr = via_ptr ? {bank, pointer} : req.addr;
      acc.wdata = req.wdata;
      acc.re = req.valid && !req.write && !self_ref;
      acc.zero_read = req.valid && !req.write && self_ref;
      acc.we = req.valid && req.write && !self_ref;
   end
endmodule

/* File: src/pcsia_core.sv */
// Contract
// - Thirteen-bit counter holds next fetch address
// - Counter low byte is software readable, writable
// - Counter bits twelve to eight hidden
// - Low byte writes take high part from latch
// - Call and jump carry eleven target bits
// - Latch bits four, three give page
// - Whole 8K word space addressable
// - Eight entry thirteen-bit hardware stack
// - Stack pointer invisible to software
// - Call and interrupt push counter
// - Returns pop full counter from stack
// - Stack moves never touch latch
// - Stack wraps, ninth push overwrites first
// - Indirect location accesses pointed register
// - Self-pointed indirect read gives zero
// - Self-pointed indirect write is dropped
// - Bank bit above pointer forms address
//
// Program counter, paging, return stack and indirect addressing.
// Assumes a decoder issuing one control strobe set per cycle and an AXI4-Lite master.
`timescale 1ns/1ns
`include "pcsia_params.svh"

module pcsia_core
   import pcsia_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input pcsia_ctl_t ctl,
   input pcsia_dreq_t dreq,
   output pcsia_dacc_t dacc,
   output logic [`PCSIA_PC_W-1:0] fetch_addr,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // --------------------------------------------------------------------------
   // Decode
   // --------------------------------------------------------------------------
   // Offsets outside the map answer with an error and change nothing
   function automatic pcsia_sel_t reg_sel(input logic [ADDR_W-1:0] a);
      unique case (a)
         ADDR_W'(`PCSIA_OFS_PC_LOW): reg_sel = PCSIA_SEL_PC_LOW;
         ADDR_W'(`PCSIA_OFS_LATCH): reg_sel = PCSIA_SEL_LATCH;
         ADDR_W'(`PCSIA_OFS_POINTER): reg_sel = PCSIA_SEL_POINTER;
         ADDR_W'(`PCSIA_OFS_BANK): reg_sel = PCSIA_SEL_BANK;
         ADDR_W'(`PCSIA_OFS_PC_FULL): reg_sel = PCSIA_SEL_PC_FULL;
         default: reg_sel = PCSIA_SEL_NONE;
      endcase
   endfunction

   // Any write of the low byte drags the high part along from the latch
   function automatic logic [`PCSIA_PC_W-1:0] pc_join(input logic [`PCSIA_LATCH_W-1:0] hi, input logic [7:0] lo);
      pc_join = {hi, lo};
   endfunction

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   logic [`PCSIA_PC_W-1:0] pc_q;
   logic [`PCSIA_PC_W-1:0] pc_d;
   logic [`PCSIA_LATCH_W-1:0] pc_high_latch_q;
   logic [`PCSIA_LATCH_W-1:0] pc_high_latch_d;
   logic [7:0] indirect_pointer_q;
   logic [7:0] indirect_pointer_d;
   logic indirect_bank_select_q;
   logic indirect_bank_select_d;

   logic aw_hold_q;
   logic aw_hold_d;
   logic w_hold_q;
   logic w_hold_d;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [ADDR_W-1:0] aw_addr_d;
   logic [7:0] w_byte_q;
   logic [7:0] w_byte_d;
   logic w_lane_q;
   logic w_lane_d;
   logic awready_q;
   logic awready_d;
   logic wready_q;
   logic wready_d;
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;

   logic arready_q;
   logic arready_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   pcsia_dacc_t dacc_q;
   pcsia_dacc_t dacc_d;

   logic push;
   logic pop;
   logic [`PCSIA_PC_W-1:0] stack_top;
   logic aw_fire;
   logic w_fire;
   logic do_wr;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane;
   pcsia_sel_t wr_sel;
   pcsia_sel_t rd_sel;
   logic sw_pcl_we;

   // --------------------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------------------
   // Stack entries are not reset, only the pointer: a return with nothing pushed pops stale data
   // Stack pointer lives inside the stack and has no bus path
   pcsia_stack #(
      .DEPTH(`PCSIA_STACK_DEPTH),
      .WIDTH(`PCSIA_PC_W)
   ) u_stack (
      .aclk(aclk),
      .aresetn(aresetn),
      .push(push),
      .pop(pop),
      .push_data(pc_q),
      .top(stack_top)
   );

   pcsia_indirect u_indirect (
      .req(dreq),
      .pointer(indirect_pointer_q),
      .bank(indirect_bank_select_q),
      .acc(dacc_d)
   );

   // --------------------------------------------------------------------------
   // Bus write path
   // --------------------------------------------------------------------------
   always_comb begin
      // Address and data may come in either order; each waits in a hold register
      aw_fire = s_axi_awvalid && awready_q;
      w_fire = s_axi_wvalid && wready_q;
      wr_addr = aw_fire ? s_axi_awaddr : aw_addr_q;
      wr_byte = w_fire ? s_axi_wdata[7:0] : w_byte_q;
      wr_lane = w_fire ? s_axi_wstrb[0] : w_lane_q;
      wr_sel = reg_sel(wr_addr);
      do_wr = (aw_hold_q || aw_fire) && (w_hold_q || w_fire) && !bvalid_q;
      aw_hold_d = (aw_hold_q || aw_fire) && !do_wr;
      w_hold_d = (w_hold_q || w_fire) && !do_wr;
      aw_addr_d = wr_addr;
      w_byte_d = wr_byte;
      w_lane_d = wr_lane;
      bvalid_d = do_wr || (bvalid_q && !s_axi_bready);
      bresp_d = bresp_q;
      if (do_wr) begin
         bresp_d = (wr_sel == PCSIA_SEL_NONE) ? `PCSIA_RESP_SLVERR : `PCSIA_RESP_OKAY;
      end
      // Both channels close until the response is taken: one write at a time
      awready_d = !aw_hold_d && !bvalid_d;
      wready_d = !w_hold_d && !bvalid_d;
      sw_pcl_we = do_wr && wr_lane && wr_sel == PCSIA_SEL_PC_LOW;
   end

   // --------------------------------------------------------------------------
   // Bus read path
   // --------------------------------------------------------------------------
   always_comb begin
      rd_sel = reg_sel(s_axi_araddr);
      rvalid_d = rvalid_q && !s_axi_rready;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = `PCSIA_RESP_OKAY;
         // A refused read still answers, with zero data and an error code
         rdata_d = '0;
         unique case (rd_sel)
            PCSIA_SEL_PC_LOW: rdata_d[7:0] = pc_q[7:0];
            PCSIA_SEL_LATCH: rdata_d[`PCSIA_LATCH_W-1:0] = pc_high_latch_q;
            PCSIA_SEL_POINTER: rdata_d[7:0] = indirect_pointer_q;
            PCSIA_SEL_BANK: rdata_d[0] = indirect_bank_select_q;
            // The high part has no software view, so the full counter is refused
            PCSIA_SEL_PC_FULL: rresp_d = `PCSIA_RESP_SLVERR;
            PCSIA_SEL_NONE: rresp_d = `PCSIA_RESP_SLVERR;
         endcase
      end
      arready_d = !rvalid_d;
   end

   // --------------------------------------------------------------------------
   // Program counter and software registers
   // --------------------------------------------------------------------------
   // Core branches outrank a bus write to the low byte in the same cycle
   always_comb begin
      pc_d = pc_q;
      push = 1'b0;
      pop = 1'b0;
      pc_high_latch_d = pc_high_latch_q;
      indirect_pointer_d = indirect_pointer_q;
      indirect_bank_select_d = indirect_bank_select_q;
      if (do_wr && wr_lane) begin
         unique case (wr_sel)
            PCSIA_SEL_LATCH: pc_high_latch_d = wr_byte[`PCSIA_LATCH_W-1:0];
            PCSIA_SEL_POINTER: indirect_pointer_d = wr_byte;
            PCSIA_SEL_BANK: indirect_bank_select_d = wr_byte[0];
            default: ;
         endcase
      end
      // The stack takes the counter as it stood before this cycle's change
      if (ctl.irq) begin
         push = 1'b1;
         pc_d = `PCSIA_IRQ_VECTOR;
      end else if (ctl.call || ctl.jump) begin
         push = ctl.call;
         pc_d = {pc_high_latch_q[`PCSIA_PAGE_HI:`PCSIA_PAGE_LO], ctl.target};
      end else if (ctl.ret) begin
         pop = 1'b1;
         pc_d = stack_top;
      end else if (ctl.pcl_we) begin
         pc_d = pc_join(pc_high_latch_q, ctl.pcl_data);
      end else if (sw_pcl_we) begin
         pc_d = pc_join(pc_high_latch_q, wr_byte);
      end else if (ctl.step) begin
         pc_d = pc_q + `PCSIA_PC_ONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_q <= `PCSIA_PC_RST;
         pc_high_latch_q <= `PCSIA_LATCH_RST;
         indirect_pointer_q <= `PCSIA_POINTER_RST;
         indirect_bank_select_q <= `PCSIA_BANK_RST;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= '0;
         w_byte_q <= '0;
         w_lane_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `PCSIA_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `PCSIA_RESP_OKAY;
         dacc_q <= '0;
      end else begin
         pc_q <= pc_d;
         pc_high_latch_q <= pc_high_latch_d;
         indirect_pointer_q <= indirect_pointer_d;
         indirect_bank_select_q <= indirect_bank_select_d;
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         aw_addr_q <= aw_addr_d;
         w_byte_q <= w_byte_d;
         w_lane_q <= w_lane_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         dacc_q <= dacc_d;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   // All outputs are plain registers, so no input reaches them in the same cycle
   assign fetch_addr = pc_q;
   assign dacc = dacc_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

/* File: verification/pcsia_core_sva.sv */
// Port checker for the program counter, stack and indirect block.
// Assumes binding onto pcsia_core from the bench top.
`timescale 1ns/1ns
`include "pcsia_params.svh"
module pcsia_core_sva
   import pcsia_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input pcsia_ctl_t ctl,
   input pcsia_dreq_t dreq,
   input pcsia_dacc_t dacc,
   input wire logic [`PCSIA_PC_W-1:0] fetch_addr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic br;
   logic calm;
   assign br = ctl.irq | ctl.call | ctl.jump;
   // Bus traffic may rewrite the counter, so quiet cycles exclude it
   assign calm = !(br | ctl.ret | ctl.pcl_we | ctl.step | s_axi_awvalid | s_axi_wvalid);
   // ---------
   // Properties
   // ---------
   a_irq_vector: assert property (ctl.irq |=> fetch_addr == `PCSIA_IRQ_VECTOR)
      else $error("interrupt did not load the vector");
   a_target_low: assert property ((ctl.call | ctl.jump) && !ctl.irq |=> fetch_addr[10:0] == $past(ctl.target))
      else $error("branch target bits wrong");
   a_call_return: assert property ((ctl.call && !ctl.irq) ##1 calm ##1 (ctl.ret && !br)
      |=> fetch_addr == $past(fetch_addr, 3))
      else $error("return did not restore the counter");
   a_step_inc: assert property (ctl.step && calm == 1'b0 && !(br | ctl.ret | ctl.pcl_we | s_axi_awvalid | s_axi_wvalid)
      |=> fetch_addr == $past(fetch_addr) + `PCSIA_PC_ONE)
      else $error("step did not advance by one");
   a_idle_hold: assert property (calm |=> $stable(fetch_addr))
      else $error("counter moved without cause");
   a_low_load: assert property (ctl.pcl_we && !(br | ctl.ret) |=> fetch_addr[7:0] == $past(ctl.pcl_data))
      else $error("low byte write lost");
   a_direct_pass: assert property (dreq.valid && dreq.addr[6:0] != 7'h00 |=> dacc.we == $past(dreq.write)
      && dacc.re == !$past(dreq.write) && dacc.addr == $past(dreq.addr) && !dacc.zero_read)
      else $error("direct access altered");
   a_self_target: assert property (dreq.valid && dreq.addr[6:0] == 7'h00
      |=> !(dacc.re | dacc.we) || dacc.addr[6:0] != 7'h00)
      else $error("indirect access reached the indirect location");
   a_zero_read: assert property (dacc.zero_read |-> !dacc.re && !dacc.we)
      else $error("zero read also accessed memory");
   a_no_request: assert property (!dreq.valid |=> !(dacc.re | dacc.we | dacc.zero_read))
      else $error("access without request");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   c_irq: cover property (ctl.irq);
   c_zero: cover property (dacc.zero_read);
   c_call_ret: cover property (ctl.call ##2 ctl.ret);
endmodule

/* File: verification/pcsia_dec_model.sv */
// Decoder and data-memory side model issuing strobes into the core.
// Assumes the bench calls op only after reset release.
`timescale 1ns/1ns
module pcsia_dec_model
   import pcsia_pkg::*;
(
   input wire logic aclk,
   output pcsia_ctl_t ctl,
   output pcsia_dreq_t dreq
);
   initial begin
      ctl = '0;
      dreq = '0;
   end
   // One strobe set per cycle, held for exactly one edge
   task automatic op(input pcsia_ctl_t c, input pcsia_dreq_t d);
      @(posedge aclk);
      ctl <= c;
      dreq <= d;
      @(posedge aclk);
      // Idle payload flips so a stale value never passes for a fresh one
      ctl <= '{target: ~c.target, pcl_data: ~c.pcl_data, default: 1'b0};
      dreq <= '{addr: ~d.addr, wdata: ~d.wdata, default: 1'b0};
      #1;
   endtask
endmodule

/* File: verification/tb.sv */
// Bench top: AXI4-Lite register tasks, decoder model and checks.
// Assumes package, design and checker compile first.
`timescale 1ns/1ns
`include "pcsia_params.svh"
module tb
   import pcsia_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   pcsia_ctl_t ctl;
   pcsia_dreq_t dreq;
   pcsia_dacc_t dacc;
   logic [`PCSIA_PC_W-1:0] fetch_addr;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fails = 0;
   int checks_done = 0;
   logic [12:0] exp_q[$];
   logic [12:0] pc0;
   always #5 aclk = ~aclk;
   pcsia_core #(.ADDR_W(8)) DUT (.aclk(aclk), .aresetn(aresetn), .ctl(ctl), .dreq(dreq), .dacc(dacc),
      .fetch_addr(fetch_addr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   pcsia_dec_model dec (.aclk(aclk), .ctl(ctl), .dreq(dreq));
   // ---------
   // Tasks
   // ---------
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] st = 4'hf);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", rdata, e);
      chk("rresp", 32'(rresp), 32'(er));
   endtask
   // Flags in order: step, call, jump, ret, irq, low byte write
   task automatic cop(input logic [5:0] f, input logic [10:0] t, input logic [7:0] p);
      dec.op(pcsia_ctl_t'({f, t, p}), '0);
   endtask
   task automatic dop(input logic w, input logic [8:0] a, input logic [7:0] d);
      dec.op('0, pcsia_dreq_t'({1'b1, w, a, d}));
   endtask
   // ---------
   // Sequence
   // ---------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(8'h00, 32'h0, 2'h0);
      rdc(8'h04, 32'h0, 2'h0);
      rdc(8'h08, 32'h0, 2'h0);
      rdc(8'h0c, 32'h0, 2'h0);
      rdc(8'h10, 32'h0, 2'h2);
      chk("pcrst", 32'(fetch_addr), 32'h0000);
      rdc(8'h14, 32'h0, 2'h2);
      wr(8'h20, 32'h1, 2'h2);
      wr(8'h04, 32'hffff_ffff, 2'h0);
      rdc(8'h04, 32'h1f, 2'h0);
      cop(6'h08, 11'h7ff, 8'h00);
      chk("jump", 32'(fetch_addr), 32'h1fff);
      cop(6'h20, 11'h000, 8'h00);
      chk("wrap", 32'(fetch_addr), 32'h0000);
      wr(8'h04, 32'h15, 2'h0);
      wr(8'h00, 32'hab, 2'h0);
      chk("pcl", 32'(fetch_addr), 32'h15ab);
      rdc(8'h00, 32'hab, 2'h0);
      wr(8'h10, 32'h0, 2'h0);
      chk("pchide", 32'(fetch_addr), 32'h15ab);
      rdc(8'h10, 32'h0, 2'h2);
      cop(6'h01, 11'h000, 8'h5a);
      chk("corepcl", 32'(fetch_addr), 32'h155a);
      wr(8'h04, 32'h08, 2'h0);
      for (int i = 1; i <= 9; i++) begin
         exp_q.push_front(fetch_addr);
         cop(6'h10, 11'(i), 8'h00);
         chk("call", 32'(fetch_addr), 32'h0800 | i);
      end
      // Ninth push sits where the first was, so it comes back twice
      exp_q[8] = exp_q[0];
      for (int i = 0; i < 9; i++) begin
         cop(6'h04, 11'h000, 8'h00);
         chk("ret", 32'(fetch_addr), 32'(exp_q[i]));
      end
      rdc(8'h04, 32'h08, 2'h0);
      pc0 = fetch_addr;
      cop(6'h02, 11'h000, 8'h00);
      chk("irq", 32'(fetch_addr), 32'h0004);
      cop(6'h20, 11'h000, 8'h00);
      chk("step", 32'(fetch_addr), 32'h0005);
      cop(6'h04, 11'h000, 8'h00);
      chk("reti", 32'(fetch_addr), 32'(pc0));
      cop(6'h10, 11'h123, 8'h00);
      cop(6'h04, 11'h000, 8'h00);
      chk("callret", 32'(fetch_addr), 32'(pc0));
      wr(8'h08, 32'h25, 2'h0);
      wr(8'h0c, 32'h1, 2'h0);
      dop(1'b0, 9'h080, 8'h00);
      chk("indrd", 32'({dacc.re, dacc.zero_read, dacc.addr}), 32'h0525);
      dop(1'b1, 9'h000, 8'h3c);
      chk("indwr", 32'({dacc.we, dacc.addr, dacc.wdata}), 32'h3_253c);
      wr(8'h08, 32'h80, 2'h0);
      dop(1'b0, 9'h100, 8'h00);
      chk("selfrd", 32'({dacc.re, dacc.zero_read, dacc.we}), 32'h2);
      dop(1'b1, 9'h000, 8'h77);
      chk("selfwr", 32'({dacc.re, dacc.we}), 32'h0);
      dop(1'b1, 9'h033, 8'h99);
      chk("direct", 32'({dacc.we, dacc.addr, dacc.wdata}), 32'h2_3399);
      wr(8'h08, 32'h11, 2'h0, 4'he);
      rdc(8'h08, 32'h80, 2'h0);
      end_of_test();
   end
   initial begin
      #100000;
      fails++;
      end_of_test();
   end
endmodule
bind pcsia_core pcsia_core_sva #(.ADDR_W(ADDR_W)) u_sva (.aclk(aclk), .aresetn(aresetn), .ctl(ctl),
   .dreq(dreq), .dacc(dacc), .fetch_addr(fetch_addr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid));
